// ### include/tws_params.svh
// Constants for the two-wire register slave
`ifndef TWS_PARAMS_SVH
`define TWS_PARAMS_SVH
`define TWS_ADDR_LOW       8'h90
`define TWS_ADDR_HIGH      8'hB8
`define TWS_LOW_BYTE_INDEX 8'h7F
`define TWS_REG_COUNT      256
`define TWS_REG_RESET      16'h0000
`endif

// ### include/tws_pkg.sv
// Types for the two-wire register slave
package tws_pkg;
    typedef enum logic [2:0] {
        TWS_IDLE  = 3'b000,
        TWS_ADDR  = 3'b001,
        TWS_INDEX = 3'b010,
        TWS_WDATA = 3'b011,
        TWS_RDATA = 3'b100,
        TWS_ACK   = 3'b101,
        TWS_MACK  = 3'b110
    } tws_state_t;
endpackage : tws_pkg

// ### rtl/tws_sync.sv
// Two-flop synchroniser with edge and bus-condition detection
`timescale 1ns/1ps
`default_nettype none
module tws_sync (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic scl_in,
    input  wire logic sda_in,
    output logic      scl,
    output logic      sda,
    output logic      scl_rise,
    output logic      scl_fall,
    output logic      start_det,
    output logic      stop_det
);
    logic [1:0] scl_meta;
    logic [1:0] sda_meta;
    logic       scl_prev;
    logic       sda_prev;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            scl_meta <= 2'b11;
            sda_meta <= 2'b11;
            scl_prev <= 1'b1;
            sda_prev <= 1'b1;
        end else begin
            scl_meta <= {scl_meta[0], scl_in};
            sda_meta <= {sda_meta[0], sda_in};
            scl_prev <= scl_meta[1];
            sda_prev <= sda_meta[1];
        end
    end

    assign scl       = scl_meta[1];
    assign sda       = sda_meta[1];
    assign scl_rise  = scl_meta[1] & ~scl_prev;
    assign scl_fall  = ~scl_meta[1] & scl_prev;
    assign start_det = scl_meta[1] & scl_prev & sda_prev & ~sda_meta[1];
    assign stop_det  = scl_meta[1] & scl_prev & ~sda_prev & sda_meta[1];
endmodule : tws_sync
`default_nettype wire

// ### rtl/tws_slave.sv
// Two-wire serial slave giving access to 16-bit internal registers
// Operation
// - Address 0x90 pin low, 0xB8/0xB9 high
// - Seven address bits, then direction bit
// - Acknowledge start plus matching address
// - Acknowledge the 8-bit register index
// - Acknowledge each written data byte
// - Two data bytes per 16-bit register
// - Index increments after each written word
// - Shift read bytes; master acknowledges continuation
// - Index advances after every 16 bits read
// - Master no-acknowledge ends read, release line
// - Byte-wise access via low byte index
// - Idle both high; slave never starts/stops
// - Start: data falls while clock high
// - Stop: data rises while clock high
// - Change data only while clock low
// - Receiver pulls low on acknowledge pulse
// - Open-drain data, only pulled low
// - Register updates only after 16 bits
// - No-acknowledge is line left high
`include "tws_params.svh"
`timescale 1ns/1ps
`default_nettype none
module tws_slave #(
    parameter int REG_COUNT = `TWS_REG_COUNT
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        bus_address_select_pin,
    input  wire logic        serial_clock_in,
    input  wire logic        host_serial_data_in,
    output logic             host_serial_data_out,
    output logic             host_serial_data_oe,
    output logic             reg_write_strobe,
    output logic [7:0]       reg_write_index,
    output logic [15:0]      reg_write_data
);
    logic               scl;
    logic               sda;
    logic               scl_rise;
    logic               scl_fall;
    logic               start_det;
    logic               stop_det;
    logic               addr_select;
    logic               addr_select_meta;

    tws_pkg::tws_state_t state;
    tws_pkg::tws_state_t ack_return;
    logic [2:0]         bit_count;
    logic [7:0]         shift_in;
    logic [7:0]         shift_out;
    logic [7:0]         reg_index;
    logic [7:0]         upper_hold;
    logic               upper_done;
    logic               reading;
    logic               read_low_half;
    logic [7:0]         byte_saved_index;
    logic               ack_drive;
    // Set once eight bits are in, so the clock fall after a start is not taken as a byte end
    logic               byte_ready;
    logic [15:0]        reg_file [REG_COUNT];

    tws_sync u_sync (
        .clk       (clk),
        .rst       (rst),
        .scl_in    (serial_clock_in),
        .sda_in    (host_serial_data_in),
        .scl       (scl),
        .sda       (sda),
        .scl_rise  (scl_rise),
        .scl_fall  (scl_fall),
        .start_det (start_det),
        .stop_det  (stop_det)
    );

    // Strap level is resynchronised since it comes from a pin
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            addr_select_meta <= 1'b0;
            addr_select      <= 1'b0;
        end else begin
            addr_select_meta <= bus_address_select_pin;
            addr_select      <= addr_select_meta;
        end
    end

    wire [7:0]  own_address   = addr_select ? `TWS_ADDR_HIGH : `TWS_ADDR_LOW;
    wire [7:0]  byte_in       = {shift_in[6:0], sda};
    wire        byte_last     = (bit_count == 3'd7);
    wire        addr_match    = (shift_in[7:1] == own_address[7:1]);
    wire        addr_is_read  = shift_in[0];
    wire        low_byte_slot = (reg_index == `TWS_LOW_BYTE_INDEX);
    wire [7:0]  word_index    = low_byte_slot ? byte_saved_index : reg_index;
    wire [15:0] word_read     = reg_file[word_index];
    wire [7:0]  read_byte     = (read_low_half | low_byte_slot) ? word_read[7:0] : word_read[15:8];
    wire [7:0]  index_plus    = reg_index + 8'h01;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state            <= tws_pkg::TWS_IDLE;
            ack_return       <= tws_pkg::TWS_IDLE;
            bit_count        <= 3'd0;
            shift_in         <= 8'h00;
            shift_out        <= 8'h00;
            reg_index        <= 8'h00;
            upper_hold       <= 8'h00;
            upper_done       <= 1'b0;
            reading          <= 1'b0;
            read_low_half    <= 1'b0;
            byte_saved_index <= 8'h00;
            ack_drive        <= 1'b0;
            byte_ready       <= 1'b0;
            reg_write_strobe <= 1'b0;
            reg_write_index  <= 8'h00;
            reg_write_data   <= `TWS_REG_RESET;
        end else begin
            reg_write_strobe <= 1'b0;
            if (start_det) begin
                // Repeated start keeps the index so a read can follow
                state      <= tws_pkg::TWS_ADDR;
                bit_count  <= 3'd0;
                byte_ready <= 1'b0;
                ack_drive  <= 1'b0;
                upper_done <= 1'b0;
            end else if (stop_det) begin
                state      <= tws_pkg::TWS_IDLE;
                ack_drive  <= 1'b0;
                upper_done <= 1'b0;
            end else if (scl_rise) begin
                unique case (state)
                    tws_pkg::TWS_ADDR, tws_pkg::TWS_INDEX, tws_pkg::TWS_WDATA: begin
                        shift_in   <= byte_in;
                        bit_count  <= bit_count + 3'd1;
                        byte_ready <= byte_last;
                    end
                    tws_pkg::TWS_MACK: begin
                        // Line left high means no-acknowledge
                        if (sda) begin
                            state <= tws_pkg::TWS_IDLE;
                        end
                    end
                    default: begin
                    end
                endcase
            end else if (scl_fall) begin
                unique case (state)
                    tws_pkg::TWS_ADDR: begin
                        if (byte_ready) begin
                            if (addr_match) begin
                                ack_drive  <= 1'b1;
                                reading    <= addr_is_read;
                                ack_return <= addr_is_read ? tws_pkg::TWS_RDATA : tws_pkg::TWS_INDEX;
                                state      <= tws_pkg::TWS_ACK;
                                read_low_half <= 1'b0;
                            end else begin
                                state <= tws_pkg::TWS_IDLE;
                            end
                        end
                    end
                    tws_pkg::TWS_INDEX: begin
                        if (byte_ready) begin
                            if (shift_in != `TWS_LOW_BYTE_INDEX) begin
                                byte_saved_index <= shift_in;
                            end
                            reg_index  <= shift_in;
                            ack_drive  <= 1'b1;
                            ack_return <= tws_pkg::TWS_WDATA;
                            state      <= tws_pkg::TWS_ACK;
                        end
                    end
                    tws_pkg::TWS_WDATA: begin
                        if (byte_ready) begin
                            ack_drive  <= 1'b1;
                            ack_return <= tws_pkg::TWS_WDATA;
                            state      <= tws_pkg::TWS_ACK;
                            if (low_byte_slot) begin
                                // Low half completes the word held from the earlier access
                                reg_write_strobe <= 1'b1;
                                reg_write_index  <= byte_saved_index;
                                reg_write_data   <= {upper_hold, shift_in};
                            end else if (!upper_done) begin
                                upper_hold <= shift_in;
                                upper_done <= 1'b1;
                            end else begin
                                reg_write_strobe <= 1'b1;
                                reg_write_index  <= reg_index;
                                reg_write_data   <= {upper_hold, shift_in};
                                upper_done       <= 1'b0;
                                reg_index        <= index_plus;
                                byte_saved_index <= index_plus;
                            end
                        end
                    end
                    tws_pkg::TWS_ACK: begin
                        ack_drive  <= 1'b0;
                        bit_count  <= 3'd0;
                        byte_ready <= 1'b0;
                        state      <= ack_return;
                        if (ack_return == tws_pkg::TWS_RDATA) begin
                            shift_out <= read_byte;
                        end
                    end
                    tws_pkg::TWS_RDATA: begin
                        bit_count <= bit_count + 3'd1;
                        if (byte_last) begin
                            state <= tws_pkg::TWS_MACK;
                            if (read_low_half && !low_byte_slot) begin
                                reg_index        <= index_plus;
                                byte_saved_index <= index_plus;
                            end
                            read_low_half <= ~read_low_half;
                        end else begin
                            shift_out <= {shift_out[6:0], 1'b0};
                        end
                    end
                    tws_pkg::TWS_MACK: begin
                        // Next byte loads on clock low so the line never moves while the clock is high
                        shift_out <= read_byte;
                        bit_count <= 3'd0;
                        state     <= tws_pkg::TWS_RDATA;
                    end
                    default: begin
                    end
                endcase
            end else if (state == tws_pkg::TWS_RDATA && scl_fall == 1'b0 && scl == 1'b0 && bit_count == 3'd0) begin
                shift_out <= shift_out;
            end
        end
    end

    // The first read byte loads after the acknowledge fall; later bytes after master ack
    always_ff @(posedge clk) begin
        if (reg_write_strobe) begin
            reg_file[reg_write_index] <= reg_write_data;
        end
    end

    wire drive_read  = (state == tws_pkg::TWS_RDATA) & ~shift_out[7];
    wire next_oe     = ack_drive | drive_read;

    // Output leaves through a flop; shift changes happen on clock low only
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            host_serial_data_out <= 1'b0;
            host_serial_data_oe  <= 1'b0;
        end else begin
            host_serial_data_out <= 1'b0;
            host_serial_data_oe  <= next_oe & ~start_det & ~stop_det;
        end
    end
endmodule : tws_slave
`default_nettype wire

// ### bench/tws_slave_monitor.sv
// Port assertions for the two-wire register slave
`timescale 1ns/1ps
`default_nettype none
module tws_slave_monitor (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        bus_address_select_pin,
    input  wire logic        serial_clock_in,
    input  wire logic        host_serial_data_in,
    input  wire logic        host_serial_data_out,
    input  wire logic        host_serial_data_oe,
    input  wire logic        reg_write_strobe,
    input  wire logic [7:0]  reg_write_index,
    input  wire logic [15:0] reg_write_data
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic [6:0] oe_run;
    // Length of the current pull; a stuck pull would hang the whole bus
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            oe_run <= 7'h00;
        end else begin
            oe_run <= host_serial_data_oe ? oe_run + 7'h01 : 7'h00;
        end
    end
    a_out_low: assert property (host_serial_data_out == 1'b0) else $error("data out not low");
    a_oe_clock_low: assert property ($changed(host_serial_data_oe) |-> !serial_clock_in)
        else $error("pull changed while clock high");
    a_pull_bounded: assert property (oe_run < 7'h64) else $error("pull held too long");
    a_ack_holds: assert property ($rose(host_serial_data_oe) |-> host_serial_data_oe [*6])
        else $error("pull dropped early");
    a_release_holds: assert property ($fell(host_serial_data_oe) |-> !host_serial_data_oe [*6])
        else $error("release too short");
    a_strobe_pulse: assert property (reg_write_strobe |=> !reg_write_strobe) else $error("strobe too long");
    a_stop_quiet: assert property (serial_clock_in && $rose(host_serial_data_in) |-> !host_serial_data_oe [*8])
        else $error("pull after stop");
    a_start_quiet: assert property (serial_clock_in && $fell(host_serial_data_in) |-> !host_serial_data_oe [*8])
        else $error("pull after start");
    c_commit: cover property (reg_write_strobe);
    c_pull: cover property ($rose(host_serial_data_oe));
    c_long_pull: cover property (oe_run > 7'h0C);
endmodule : tws_slave_monitor
bind tws_slave tws_slave_monitor i_tws_slave_monitor (.clk(clk), .rst(rst),
    .bus_address_select_pin(bus_address_select_pin), .serial_clock_in(serial_clock_in),
    .host_serial_data_in(host_serial_data_in), .host_serial_data_out(host_serial_data_out),
    .host_serial_data_oe(host_serial_data_oe), .reg_write_strobe(reg_write_strobe),
    .reg_write_index(reg_write_index), .reg_write_data(reg_write_data));
`default_nettype wire

// ### bench/tws_host_model.sv
// Behavioural two-wire bus master, 320 ns bit period
`timescale 1ns/1ps
`default_nettype none
module tws_host_model (
    output logic      scl,
    output logic      sda_pull,
    input  wire logic sda
);
    // Clock stands high between frames; low phase is the longer so the slave has time to turn
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    task automatic bit_io(input logic b, output logic r);
        sda_pull = !b;
        #160 scl = 1'b1;
        #60 r = sda;
        #60 scl = 1'b0;
        #40;
    endtask : bit_io
    task automatic start_cond();
        sda_pull = 1'b0;
        #160 scl = 1'b1;
        #60 sda_pull = 1'b1;
        #60 scl = 1'b0;
        #40;
    endtask : start_cond
    task automatic stop_cond();
        sda_pull = 1'b1;
        #160 scl = 1'b1;
        #60 sda_pull = 1'b0;
        #160;
    endtask : stop_cond
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask : send_byte
    task automatic recv_byte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(last, r);
    endtask : recv_byte
endmodule : tws_host_model
`default_nettype wire

// ### bench/tws_slave_test.sv
// Self-checking testbench for the two-wire register slave
`timescale 1ns/1ps
`default_nettype none
module tws_slave_test;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        sel = 1'b1;
    logic        scl, pull, oe, out, stb;
    logic [7:0]  idx;
    logic [15:0] wdat;
    logic [23:0] seen[$];
    int          mismatches = 0;
    int          check_count = 0;
    wire logic   sda = !(pull || oe);
    always #20 clk = !clk;
    tws_host_model i_tws_host_model (.scl(scl), .sda_pull(pull), .sda(sda));
    tws_slave i_tws_slave (.clk(clk), .rst(rst), .bus_address_select_pin(sel), .serial_clock_in(scl),
        .host_serial_data_in(sda), .host_serial_data_out(out), .host_serial_data_oe(oe),
        .reg_write_strobe(stb), .reg_write_index(idx), .reg_write_data(wdat));
    always @(posedge clk) if (stb === 1'b1) seen.push_back({idx, wdat});
    task automatic chk_val(input string what, input logic [23:0] exp, input logic [23:0] got);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : chk_val
    task automatic chk_ack(input string what, input logic exp, input logic got);
        chk_val(what, 24'(exp), 24'(got));
    endtask : chk_ack
    task automatic expect_word(input logic [7:0] i, input logic [15:0] d);
        logic [23:0] got;
        got = 'x;
        if (seen.size() > 0) got = seen.pop_front();
        chk_val("register commit", {i, d}, got);
    endtask : expect_word
    task automatic go(); i_tws_host_model.start_cond(); endtask : go
    task automatic halt(); i_tws_host_model.stop_cond(); endtask : halt
    task automatic send(input logic [7:0] b, input logic exp);
        logic a;
        i_tws_host_model.send_byte(b, a);
        chk_ack("acknowledge", exp, a);
    endtask : send
    task automatic fetch(input logic [7:0] exp, input logic last);
        logic [7:0] d;
        i_tws_host_model.recv_byte(last, d);
        chk_val("read byte", 24'(exp), 24'(d));
    endtask : fetch
    task automatic point(input logic [7:0] a, input logic [7:0] i);
        go();
        send(a, 1'b1);
        send(i, 1'b1);
    endtask : point
    task automatic t_burst();
        point(8'hB8, 8'h09);
        send(8'h02, 1'b1);
        send(8'h84, 1'b1);
        send(8'h12, 1'b1);
        send(8'h34, 1'b1);
        halt();
        expect_word(8'h09, 16'h0284);
        expect_word(8'h0A, 16'h1234);
    endtask : t_burst
    task automatic t_read();
        point(8'hB8, 8'h09);
        go();
        send(8'hB9, 1'b1);
        fetch(8'h02, 1'b0);
        fetch(8'h84, 1'b0);
        fetch(8'h12, 1'b0);
        fetch(8'h34, 1'b1);
        halt();
    endtask : t_read
    task automatic t_byte_wise();
        point(8'hB8, 8'h30);
        send(8'h55, 1'b1);
        halt();
        chk_val("commit count", 24'h00_0000, 24'(seen.size()));
        point(8'hB8, 8'h20);
        send(8'hAB, 1'b1);
        point(8'hB8, 8'h7F);
        send(8'hCD, 1'b1);
        halt();
        expect_word(8'h20, 16'hABCD);
        point(8'hB8, 8'h20);
        go();
        send(8'hB9, 1'b1);
        fetch(8'hAB, 1'b1);
        point(8'hB8, 8'h7F);
        go();
        send(8'hB9, 1'b1);
        fetch(8'hCD, 1'b1);
        halt();
    endtask : t_byte_wise
    task automatic t_address_pin();
        @(posedge clk);
        #1 sel = 1'b0;
        repeat (4) @(posedge clk);
        go();
        send(8'hB8, 1'b0);
        halt();
        point(8'h90, 8'h40);
        send(8'h5A, 1'b1);
        send(8'hC3, 1'b1);
        halt();
        expect_word(8'h40, 16'h5AC3);
        point(8'h90, 8'h40);
        go();
        send(8'h91, 1'b1);
        fetch(8'h5A, 1'b0);
        fetch(8'hC3, 1'b1);
        halt();
    endtask : t_address_pin
    task automatic close_out();
        if (mismatches == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : close_out
    initial begin
        repeat (4) @(posedge clk);
        #1 rst = 1'b0;
        repeat (4) @(posedge clk);
        chk_ack("idle data", 1'b1, sda);
        t_burst();
        t_read();
        t_byte_wise();
        t_address_pin();
        close_out();
    end
    initial begin
        #1_000_000;
        mismatches++;
        close_out();
    end
endmodule : tws_slave_test
`default_nettype wire
